//--- src/nvm_clock_divider_map.svh
// Register offsets, field positions, reset values and timing figures of the nvm clock divider
`ifndef NVM_CLOCK_DIVIDER_MAP_SVH
`define NVM_CLOCK_DIVIDER_MAP_SVH

// ============================================================
// Register offsets (byte-wide registers, 4-bit address)
`define NVM_ADDR_W 4
`define NVM_ADDR_CFG 4'h0
`define NVM_ADDR_SHADOW_LO 4'h1
`define NVM_ADDR_SHADOW_HI 4'h3
`define NVM_ADDR_STATUS 4'h4
`define NVM_NUM_REGS 4'h9

// ============================================================
// Divider register fields, shadow register count and key width
`define NVM_FLAG_BIT 7
`define NVM_PRESC_BIT 6
`define NVM_DIV_MSB 5
`define NVM_DIV_W 6
`define NVM_CFG_RST 8'h00
`define NVM_SHADOW_RST 8'h00
`define NVM_SHADOW_N 3
`define NVM_KEY_W 64

// ============================================================
// Prescaler and timing
`define NVM_PRESC_W 3
`define NVM_PRESC_LAST 3'h7
`define NVM_PRESC_SHIFT 4'h3
`define NVM_GAP_W 10
`define NVM_CLK_NS 100
`define NVM_PULSE_MIN_NS 5000
`define NVM_PULSE_MAX_NS 6700
`define NVM_PULSE_MIN_CYC ((`NVM_PULSE_MIN_NS + `NVM_CLK_NS - 1) / `NVM_CLK_NS)
`define NVM_PULSE_MAX_CYC (`NVM_PULSE_MAX_NS / `NVM_CLK_NS)

`endif

//--- src/nvm_clock_divider_pkg.sv
// State types of the nvm clock divider and its two counters
package nvm_clock_divider_pkg;

    typedef struct packed {
        logic [2:0] cnt;
    } presc_state_t;

    typedef struct packed {
        logic [5:0] cnt;
    } div_state_t;

    typedef struct packed {
        logic loaded;
        logic presc;
        logic [5:0] div;
        logic boot_done;
        logic [2:0][7:0] shadow;
        logic [7:0] rdata;
        logic tick;
        logic key_match;
        logic [9:0] gap;
        logic seen;
    } top_state_t;

endpackage : nvm_clock_divider_pkg

//--- src/nvm_prescaler.sv
// Optional divide-by-eight stage ahead of the divisor counter
`include "nvm_clock_divider_map.svh"

module nvm_prescaler (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic run,
    input wire logic by_eight,
    output logic stage_en
);

    nvm_clock_divider_pkg::presc_state_t st_ff;
    nvm_clock_divider_pkg::presc_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (run) begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
        end else begin
            nxt_st.cnt = 3'h0;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stage_en = run && (!by_eight || st_ff.cnt == `NVM_PRESC_LAST);

endmodule : nvm_prescaler

//--- src/nvm_divisor_counter.sv
// Divide-by-(divisor+1) counter on the prescaler enable
`include "nvm_clock_divider_map.svh"

module nvm_divisor_counter (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic run,
    input wire logic step,
    input wire logic [5:0] divisor,
    output logic tick
);

    nvm_clock_divider_pkg::div_state_t st_ff;
    nvm_clock_divider_pkg::div_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (!run) begin
            nxt_st.cnt = 6'h00;
        end else if (step) begin
            nxt_st.cnt = (st_ff.cnt == divisor) ? 6'h00 : st_ff.cnt + 6'h01;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = run && step && st_ff.cnt == divisor;

endmodule : nvm_divisor_counter

//--- src/nvm_clock_divider.sv
// Write-once nvm clock divider register, timing clock enable and program/erase gate
`include "nvm_clock_divider_map.svh"

module nvm_clock_divider (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [23:0] nv_config,
    input wire logic [63:0] nv_key,
    input wire logic [63:0] key_candidate,
    output logic key_match,
    input wire logic pe_request,
    output logic pe_grant,
    output logic timing_tick,
    output logic divisor_loaded_flag
);

    // ============================================================
    // State
    nvm_clock_divider_pkg::top_state_t st_ff;
    nvm_clock_divider_pkg::top_state_t nxt_st;

    logic stage_en;
    logic div_tick;
    logic [9:0] period;
    logic cfg_ok;
    logic cfg_hit;

    // ============================================================
    // Timing chain
    // Counters only run once the divider is loaded, so no pulse
    // ever leaves with an unconfigured divisor.
    nvm_prescaler nvm_prescaler_i (
        .clock(clock),
        .arst_n(arst_n),
        .run(st_ff.loaded),
        .by_eight(st_ff.presc),
        .stage_en(stage_en)
    );

    nvm_divisor_counter nvm_divisor_counter_i (
        .clock(clock),
        .arst_n(arst_n),
        .run(st_ff.loaded),
        .step(stage_en),
        .divisor(st_ff.div),
        .tick(div_tick)
    );

    // Pulse length in bus cycles, used for the range status bit
    assign period = st_ff.presc ?
        ({4'h0, st_ff.div} + 10'h001) << `NVM_PRESC_SHIFT :
        ({4'h0, st_ff.div} + 10'h001);
    assign cfg_ok = st_ff.loaded &&
        period >= 10'(`NVM_PULSE_MIN_CYC) &&
        period <= 10'(`NVM_PULSE_MAX_CYC);

    assign cfg_hit = addr == `NVM_ADDR_CFG;

    // ============================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = div_tick;
        // Key stays inside the array; only the match result leaves
        nxt_st.key_match = key_candidate == nv_key;

        // Shadow copy on first edge after reset release; ports may not
        // feed the asynchronous reset branch.
        if (!st_ff.boot_done) begin
            nxt_st.boot_done = 1'b1;
            nxt_st.shadow = nv_config;
        end

        // Only the first write after reset lands; the flag bit of
        // the write data is ignored either way.
        if (wr && cfg_hit && !st_ff.loaded) begin
            nxt_st.loaded = 1'b1;
            nxt_st.presc = wdata[`NVM_PRESC_BIT];
            nxt_st.div = wdata[`NVM_DIV_MSB:0];
        end

        if (rd) begin
            if (cfg_hit) begin
                nxt_st.rdata = {st_ff.loaded, st_ff.presc, st_ff.div};
            end else if (addr >= `NVM_ADDR_SHADOW_LO && addr <= `NVM_ADDR_SHADOW_HI) begin
                nxt_st.rdata = st_ff.shadow[2'(addr - `NVM_ADDR_SHADOW_LO)];
            end else if (addr == `NVM_ADDR_STATUS) begin
                nxt_st.rdata = {7'h00, cfg_ok};
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end

        // Assertion helper: bus cycles since the previous timing pulse
        if (st_ff.tick) begin
            nxt_st.gap = 10'h001;
            nxt_st.seen = 1'b1;
        end else if (st_ff.gap != 10'h3ff) begin
            nxt_st.gap = st_ff.gap + 10'h001;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ============================================================
    // Outputs
    assign rdata = st_ff.rdata;
    assign key_match = st_ff.key_match;
    assign timing_tick = st_ff.tick;
    assign divisor_loaded_flag = st_ff.loaded;
    assign pe_grant = pe_request && st_ff.loaded;

    // ============================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_flag_read_only: assert property (
        st_ff.loaded && wr && cfg_hit && !wdata[`NVM_FLAG_BIT]
        |=> divisor_loaded_flag ##1 divisor_loaded_flag)
        else $error("loaded flag changed by a write");

    a_write_once: assert property (
        st_ff.loaded && wr && cfg_hit
        |=> $stable(st_ff.presc) && $stable(st_ff.div))
        else $error("divider changed by a second write");

    a_first_write: assert property (
        !st_ff.loaded && wr && cfg_hit
        |=> divisor_loaded_flag && st_ff.div == $past(wdata[5:0])
            && st_ff.presc == $past(wdata[6]))
        else $error("first write not captured");

    a_cfg_readback: assert property (
        rd && cfg_hit
        |=> rdata == {$past(st_ff.loaded), $past(st_ff.presc), $past(st_ff.div)})
        else $error("divider readback wrong");

    a_pe_gate: assert property (
        pe_request |-> pe_grant == divisor_loaded_flag)
        else $error("program/erase gate wrong");

    a_no_tick_unloaded: assert property (
        !st_ff.loaded |=> !timing_tick)
        else $error("timing pulse before divider load");

    a_prescale_gap: assert property (
        st_ff.presc && st_ff.div == 6'h00 && timing_tick
        |=> !timing_tick [*7] ##1 timing_tick)
        else $error("prescaled pulse spacing not eight");

    a_div_zero_pass: assert property (
        !st_ff.presc && st_ff.div == 6'h00 && timing_tick |=> timing_tick)
        else $error("zero divisor does not pass input");

    a_pulse_period: assert property (
        timing_tick && st_ff.seen |-> st_ff.gap == period)
        else $error("timing pulse period wrong");

    a_next_tick_due: assert property (
        st_ff.loaded && timing_tick |-> ##[1:512] timing_tick)
        else $error("timing pulse missing");

    a_shadow_load: assert property (
        $rose(st_ff.boot_done) |-> st_ff.shadow == $past(nv_config))
        else $error("shadow registers not loaded at reset");

    a_unmapped_zero: assert property (
        rd && addr >= `NVM_NUM_REGS |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    a_key_compare: assert property (
        key_candidate == nv_key |=> key_match)
        else $error("key match missing");

    c_first_load: cover property (!st_ff.loaded && wr && cfg_hit);
    c_second_write: cover property (st_ff.loaded && wr && cfg_hit);
    c_prescaled_tick: cover property (st_ff.presc && timing_tick);
    c_grant: cover property (pe_grant);

endmodule : nvm_clock_divider

//--- dv/nvm_clock_divider_test.sv
// Self-checking testbench of the write-once nvm clock divider
module nvm_clock_divider_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock;
    logic arst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic [23:0] nv_config;
    logic [63:0] nv_key;
    logic [63:0] key_candidate;
    logic key_match;
    logic pe_request;
    logic pe_grant;
    logic timing_tick;
    logic divisor_loaded_flag;
    int err_total;
    int compares;

    nvm_clock_divider nvm_clock_divider_i (
        .clock(clock), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .nv_config(nv_config), .nv_key(nv_key),
        .key_candidate(key_candidate), .key_match(key_match), .pe_request(pe_request),
        .pe_grant(pe_grant), .timing_tick(timing_tick),
        .divisor_loaded_flag(divisor_loaded_flag)
    );

    // ============================================================
    // Clock, bus tasks and comparison
    always #50 clock = ~clock;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask : rd_chk

    // Counts cycles between two consecutive ticks; the first tick may be early
    task automatic period_chk(input logic [7:0] exp);
        int n;
        int p;
        n = 0;
        p = 1;
        @(posedge clock);
        #1;
        while (timing_tick !== 1'b1 && n < 2000) begin
            @(posedge clock);
            #1;
            n++;
        end
        @(posedge clock);
        #1;
        while (timing_tick !== 1'b1 && p < 2000) begin
            @(posedge clock);
            #1;
            p++;
        end
        chk("tick period", exp, 8'(p));
    endtask : period_chk

    task automatic do_reset;
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
    endtask : do_reset

    // ============================================================
    // Scenarios
    task automatic t_reset_state;
        int ticks;
        ticks = 0;
        pe_request <= 1'b1;
        repeat (100) begin
            @(posedge clock);
            #1;
            if (timing_tick === 1'b1) ticks++;
        end
        chk("ticks before load", 8'h00, 8'(ticks));
        chk("flag at reset", 8'h00, {7'h00, divisor_loaded_flag});
        chk("grant unloaded", 8'h00, {7'h00, pe_grant});
        rd_chk("divider reset", 4'h0, 8'h00);
        rd_chk("shadow 0", 4'h1, nv_config[7:0]);
        rd_chk("shadow 1", 4'h2, nv_config[15:8]);
        rd_chk("shadow 2", 4'h3, nv_config[23:16]);
        rd_chk("reserved", 4'h5, 8'h00);
        rd_chk("unmapped", 4'hf, 8'h00);
    endtask : t_reset_state

    task automatic t_write_once;
        bus_wr(4'h0, 8'h31);
        chk("flag set", 8'h01, {7'h00, divisor_loaded_flag});
        chk("grant loaded", 8'h01, {7'h00, pe_grant});
        rd_chk("first write", 4'h0, 8'hb1);
        bus_wr(4'h0, 8'h7f);
        bus_wr(4'h0, 8'h00);
        rd_chk("later writes", 4'h0, 8'hb1);
        bus_wr(4'h1, 8'hff);
        rd_chk("shadow read only", 4'h1, nv_config[7:0]);
        period_chk(8'd50);
        rd_chk("status in range", 4'h4, 8'h01);
    endtask : t_write_once

    task automatic t_prescale;
        do_reset();
        rd_chk("divider after reset", 4'h0, 8'h00);
        bus_wr(4'h0, 8'hc0);
        rd_chk("prescale write", 4'h0, 8'hc0);
        period_chk(8'd8);
        rd_chk("status out of range", 4'h4, 8'h00);
        @(posedge clock);
        pe_request <= 1'b0;
        @(posedge clock);
        #1;
        chk("grant idle", 8'h00, {7'h00, pe_grant});
    endtask : t_prescale

    task automatic t_key;
        @(posedge clock);
        key_candidate <= nv_key;
        repeat (2) @(posedge clock);
        #1;
        chk("key equal", 8'h01, {7'h00, key_match});
        @(posedge clock);
        key_candidate <= nv_key ^ 64'h0000_0000_0000_0100;
        repeat (2) @(posedge clock);
        #1;
        chk("key differs", 8'h00, {7'h00, key_match});
    endtask : t_key

    // ============================================================
    // Sequence and verdict
    task automatic close_out;
        if (err_total == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        clock = 1'b0;
        arst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        nv_config = 24'h3c_a55a;
        nv_key = 64'h0123_4567_89ab_cdef;
        key_candidate = 64'h0000_0000_0000_0000;
        pe_request = 1'b0;
        err_total = 0;
        compares = 0;
        do_reset();
        t_reset_state();
        t_write_once();
        t_prescale();
        t_key();
        close_out();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        #(20000 * 100);
        err_total++;
        close_out();
    end
endmodule : nvm_clock_divider_test
